// ### verilog/ubp_power_irq.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module ubp_power_irq #(
	parameter int unsigned WAKE_CYCLES = ubp_pkg::WAKE_CYC,
	parameter int unsigned IDLE_CYCLES = ubp_pkg::IDLE_CYC,
	parameter int unsigned RSTDET_CYCLES = ubp_pkg::RSTDET_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic bus_se0,
	input wire logic bus_k,
	input wire logic bus_idle,
	input wire logic [4:1] ep_dir_in,
	input wire logic [4:0] ep_in_rdy_clr,
	input wire logic [4:0] ep_out_rdy_set,
	input wire logic [4:0] ep_stall_set,
	input wire logic [4:1] ep_flush,
	input wire logic ep0_setup_end_set,
	input wire logic ep0_data_end_clr,
	output logic resume_drive,
	output logic irq
);
	import ubp_pkg::*;

	localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);
	localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] IDLE_N = CNT_W'(IDLE_CYCLES);
	localparam logic [CNT_W-1:0] RSTDET_N = CNT_W'(RSTDET_CYCLES);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	wire setup = psel && !penable;
	wire wr = psel && penable && pwrite;
	wire hit_pc = paddr == ADDR_POWER_CTRL;
	wire hit_ep = paddr == ADDR_EP_PEND;
	wire hit_bp = paddr == ADDR_BUS_PEND;
	wire hit_ee = paddr == ADDR_EP_EN;
	wire hit_be = paddr == ADDR_BUS_EN;
	wire mapped = hit_pc | hit_ep | hit_bp | hit_ee | hit_be;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	wire wr_pc = wr && hit_pc;
	wire wr_ep = wr && hit_ep;
	wire wr_bp = wr && hit_bp;

	ubp_state_t state_reg, state_next;
	logic susp_en_reg, wake_reg, rst_lvl_reg, woke_reg;
	logic [4:0] ep_pend_reg, ep_en_reg;
	logic [2:0] bus_pend_reg;
	logic [1:0] bus_en_reg;
	logic [CNT_W-1:0] idle_cnt_reg, wake_cnt_reg, se0_cnt_reg;
	logic [31:0] prdata_reg;

	// ----------------------------------------
	// bus line watchers
	// ----------------------------------------
	wire in_susp = state_reg == ST_SUSP || state_reg == ST_HOLD;
	wire driving = state_reg == ST_DRIVE;
	// own K echoes back while driving, so it is not taken as host resume
	wire host_res = in_susp && (bus_k || bus_se0);
	wire idle_run = bus_idle && !driving;
	wire idle_evt = idle_run && idle_cnt_reg == IDLE_LAST;
	wire wake_done = driving && wake_cnt_reg == WAKE_LAST;
	// after a reset woke us, the full idle interval of SE0 is needed
	wire [CNT_W-1:0] rst_thr = woke_reg ? IDLE_N : RSTDET_N;
	wire rst_lvl_next = bus_se0 && se0_cnt_reg >= rst_thr;
	wire rst_evt = rst_lvl_next && !rst_lvl_reg;
	wire woke_next = bus_se0 && (woke_reg || host_res);
	wire [CNT_W-1:0] se0_cnt_next = !bus_se0 ? '0 :
		(se0_cnt_reg == IDLE_N) ? se0_cnt_reg : se0_cnt_reg + 1'b1;
	wire [CNT_W-1:0] idle_cnt_next = (!idle_run || idle_evt) ? '0 :
		idle_cnt_reg + 1'b1;
	wire [CNT_W-1:0] wake_cnt_next = driving ? wake_cnt_reg + 1'b1 : '0;

	// ----------------------------------------
	// power state
	// ----------------------------------------
	wire sw_wake1 = wr_pc && pwdata[PC_WAKE];
	wire sw_wake0 = wr_pc && !pwdata[PC_WAKE] && wake_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_ACTIVE: begin
				if (idle_evt && susp_en_reg)
					state_next = ST_SUSP;
			end
			ST_SUSP: begin
				if (host_res)
					state_next = ST_ACTIVE;
				else if (sw_wake1)
					state_next = ST_DRIVE;
			end
			ST_DRIVE: begin
				if (sw_wake0)
					state_next = ST_ACTIVE;
				else if (wake_done)
					state_next = ST_HOLD;
			end
			ST_HOLD: begin
				if (host_res || sw_wake0)
					state_next = ST_ACTIVE;
			end
			default: state_next = ST_ACTIVE;
		endcase
	end

	// set by software, cleared by software or at end of signaling
	wire wake_next = wake_done ? 1'b0 :
		wr_pc ? pwdata[PC_WAKE] : wake_reg;

	assign resume_drive = driving;

	// ----------------------------------------
	// pending and enable registers
	// ----------------------------------------
	logic [4:0] ep_set;
	assign ep_set[0] = ep_out_rdy_set[0] | ep_in_rdy_clr[0] | ep_stall_set[0] |
		ep0_setup_end_set | ep0_data_end_clr;
	genvar gi;
	generate
		for (gi = 1; gi < 5; gi++) begin : g_ep
			assign ep_set[gi] = ep_dir_in[gi] ?
				(ep_in_rdy_clr[gi] | ep_flush[gi] | ep_stall_set[gi]) :
				(ep_out_rdy_set[gi] | ep_stall_set[gi]);
		end
	endgenerate

	wire [2:0] bus_set = {rst_evt, host_res, idle_evt};
	// a set in the same cycle as a clear wins
	wire [4:0] ep_clr = wr_ep ? pwdata[4:0] : 5'h00;
	wire [2:0] bus_clr = wr_bp ? pwdata[2:0] : 3'h0;
	wire [4:0] ep_pend_next = (ep_pend_reg & ~ep_clr) | ep_set;
	wire [2:0] bus_pend_next = (bus_pend_reg & ~bus_clr) | bus_set;

	// resume has no enable of its own and always reaches the interrupt
	wire [2:0] bus_en_eff = {bus_en_reg[1], 1'b1, bus_en_reg[0]};
	assign irq = |(ep_pend_reg & ep_en_reg) |
		|(bus_pend_reg & bus_en_eff);

	// ----------------------------------------
	// read data
	// ----------------------------------------
	wire [7:0] pc_view = {4'h0, rst_lvl_reg, wake_reg, in_susp | driving,
		susp_en_reg};
	wire [7:0] rd_byte = hit_pc ? pc_view :
		hit_ep ? {3'h0, ep_pend_reg} :
		hit_bp ? {5'h00, bus_pend_reg} :
		hit_ee ? {3'h0, ep_en_reg} :
		hit_be ? {5'h00, bus_en_reg[1], 1'b0, bus_en_reg[0]} : 8'h00;
	assign prdata = prdata_reg;

	// ----------------------------------------
	// flip-flops
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_ACTIVE;
			susp_en_reg <= POWER_RST[PC_SUSP_EN];
			wake_reg <= POWER_RST[PC_WAKE];
			rst_lvl_reg <= POWER_RST[PC_BUS_RST];
			woke_reg <= 1'b0;
			idle_cnt_reg <= '0;
			wake_cnt_reg <= '0;
			se0_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			if (wr_pc)
				susp_en_reg <= pwdata[PC_SUSP_EN];
			wake_reg <= wake_next;
			rst_lvl_reg <= rst_lvl_next;
			woke_reg <= woke_next;
			idle_cnt_reg <= idle_cnt_next;
			wake_cnt_reg <= wake_cnt_next;
			se0_cnt_reg <= se0_cnt_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep_pend_reg <= EP_PEND_RST[4:0];
			bus_pend_reg <= BUS_PEND_RST[2:0];
			ep_en_reg <= EP_EN_RST[4:0];
			bus_en_reg <= {BUS_EN_RST[BI_RESET], BUS_EN_RST[BI_SUSPEND]};
			prdata_reg <= 32'h0000_0000;
		end else begin
			ep_pend_reg <= ep_pend_next;
			bus_pend_reg <= bus_pend_next;
			if (wr && hit_ee)
				ep_en_reg <= pwdata[4:0];
			if (wr && hit_be)
				bus_en_reg <= {pwdata[BI_RESET], pwdata[BI_SUSPEND]};
			if (setup)
				prdata_reg <= {24'h00_0000, rd_byte};
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	rst_follow_a: assert property (!bus_se0 |=> !pc_view[PC_BUS_RST])
		else $error("bus reset status outlived SE0");

	wake_end_a: assert property (wake_done && !sw_wake0 |=>
		!resume_drive && !wake_reg && pc_view[PC_SUSPENDED])
		else $error("resume signaling did not end cleanly");

	wake_start_a: assert property (state_reg == ST_SUSP && !host_res && sw_wake1
		|=> resume_drive [*2])
		else $error("resume signaling not started");

	susp_entry_a: assert property (state_reg == ST_ACTIVE && idle_evt && susp_en_reg
		|=> pc_view[PC_SUSPENDED] && bus_pend_reg[BI_SUSPEND])
		else $error("suspend not entered");

	susp_exit_a: assert property (host_res |=> !pc_view[PC_SUSPENDED]
		&& bus_pend_reg[BI_RESUME])
		else $error("host resume did not wake device");

	no_susp_a: assert property (!susp_en_reg && !pc_view[PC_SUSPENDED]
		|=> !pc_view[PC_SUSPENDED])
		else $error("suspend entered while not allowed");

	w1c_ep_a: assert property (wr_ep && ep_set == 5'h00
		|=> ep_pend_reg == ($past(ep_pend_reg) & ~$past(pwdata[4:0])))
		else $error("endpoint pending write-one-clear wrong");

	ep_evt_a: assert property (|ep_set |=> (ep_pend_reg & $past(ep_set))
		== $past(ep_set))
		else $error("endpoint event lost");

	rst_evt_a: assert property ($rose(rst_lvl_reg) |-> bus_pend_reg[BI_RESET])
		else $error("bus reset pending not set");

	rst_late_a: assert property ($rose(rst_lvl_reg) && woke_reg
		|-> se0_cnt_reg >= IDLE_N && bus_pend_reg[BI_RESUME] | $past(bus_clr[BI_RESUME]))
		else $error("reset after wake reported too early");

	idle_rep_a: assert property (idle_evt |=> bus_pend_reg[BI_SUSPEND]
		&& idle_cnt_reg == '0)
		else $error("idle interval not reported");

	susp_mask_a: assert property (!bus_en_reg[0] && ep_pend_reg == 5'h00
		&& bus_pend_reg[2:1] == 2'b00 |-> !irq)
		else $error("masked suspend raised interrupt");

	irq_hold_a: assert property (irq && !wr |=> irq)
		else $error("interrupt dropped without a clear");

	// per-rule checks on the state, pending and enable flops
	rst_set_a: assert property (bus_se0 && se0_cnt_reg >= rst_thr
		|=> pc_view[PC_BUS_RST])
		else $error("bus reset status not raised");

	rst_keep_a: assert property (rst_lvl_reg && bus_se0 |=> rst_lvl_reg)
		else $error("bus reset status dropped during SE0");

	wake_hold_a: assert property (driving && !wake_done && !sw_wake0
		|=> resume_drive)
		else $error("resume signaling cut short");

	idle_nodrv_a: assert property (state_reg == ST_ACTIVE |=> !resume_drive)
		else $error("resume driven while awake");

	drive_stop_a: assert property (driving && sw_wake0
		|=> !resume_drive && !pc_view[PC_SUSPENDED])
		else $error("software stop of resume ignored");

	hold_exit_a: assert property (state_reg == ST_HOLD && (host_res || sw_wake0)
		|=> !pc_view[PC_SUSPENDED])
		else $error("suspended flag stuck after wake");

	allow_wr_a: assert property (wr_pc
		|=> susp_en_reg == $past(pwdata[PC_SUSP_EN]))
		else $error("suspend allow bit not written");

	w1c_bus_a: assert property (wr_bp && bus_set == 3'h0
		|=> bus_pend_reg == ($past(bus_pend_reg) & ~$past(pwdata[2:0])))
		else $error("bus pending write-one-clear wrong");

	pend_keep_a: assert property (!wr_ep
		|=> (ep_pend_reg & $past(ep_pend_reg)) == $past(ep_pend_reg))
		else $error("endpoint pending lost without a clear");

	ep_flush_a: assert property (ep_dir_in[1] && ep_flush[1] |=> ep_pend_reg[1])
		else $error("flush of IN endpoint not reported");

	ep_out_a: assert property (!ep_dir_in[2] && ep_out_rdy_set[2]
		|=> ep_pend_reg[2])
		else $error("OUT packet ready not reported");

	ep0_evt_a: assert property (ep0_setup_end_set || ep0_data_end_clr
		|=> ep_pend_reg[0])
		else $error("control transfer event not reported");

	resume_only_a: assert property (!in_susp && !bus_pend_reg[BI_RESUME]
		|=> !bus_pend_reg[BI_RESUME])
		else $error("resume reported while awake");

	rst_wait_a: assert property (woke_reg && se0_cnt_reg < IDLE_N
		|=> !rst_lvl_reg)
		else $error("reset after wake came before full SE0 interval");

	en_keep_a: assert property (!(wr && hit_be)
		|=> bus_en_reg == $past(bus_en_reg))
		else $error("bus enable changed without a write");

	irq_rst_a: assert property (bus_pend_reg[BI_RESET] && bus_en_reg[1] |-> irq)
		else $error("enabled reset pending did not interrupt");

	irq_ep_a: assert property (|(ep_pend_reg & ep_en_reg) |-> irq)
		else $error("enabled endpoint pending did not interrupt");

	// a host resume (K or SE0) that wakes the held state is the least travelled exit
	hold_c: cover property (state_reg == ST_HOLD && host_res);
	susp_c: cover property (state_reg == ST_SUSP);
	wake_c: cover property (wake_done);
	rst_wake_c: cover property ($rose(rst_lvl_reg) && woke_reg);
	irq_c: cover property ($rose(irq));

endmodule

`default_nettype wire

// ### include/ubp_pkg.sv
package ubp_pkg;

	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [31:0] ADDR_POWER_CTRL = 32'h5200_0144;
	localparam logic [31:0] ADDR_EP_PEND = 32'h5200_0148;
	localparam logic [31:0] ADDR_BUS_PEND = 32'h5200_0158;
	localparam logic [31:0] ADDR_EP_EN = 32'h5200_015c;
	localparam logic [31:0] ADDR_BUS_EN = 32'h5200_016c;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PC_SUSP_EN = 0;
	localparam int PC_SUSPENDED = 1;
	localparam int PC_WAKE = 2;
	localparam int PC_BUS_RST = 3;
	localparam int BI_SUSPEND = 0;
	localparam int BI_RESUME = 1;
	localparam int BI_RESET = 2;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] POWER_RST = 8'h00;
	localparam logic [7:0] EP_PEND_RST = 8'h00;
	localparam logic [7:0] BUS_PEND_RST = 8'h00;
	localparam logic [7:0] EP_EN_RST = 8'h1f;
	localparam logic [7:0] BUS_EN_RST = 8'h04;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int T_WAKE_MS = 10;
	localparam int T_IDLE_MS = 3;
	localparam int T_RSTDET_NS = 2500;
	localparam int WAKE_CYC = T_WAKE_MS * CLK_MHZ * 1000;
	localparam int IDLE_CYC = T_IDLE_MS * CLK_MHZ * 1000;
	localparam int RSTDET_CYC = (T_RSTDET_NS * CLK_MHZ + 999) / 1000;
	localparam int CNT_W = 22;

	typedef enum logic [3:0] {
		ST_ACTIVE = 4'b0001,
		ST_SUSP = 4'b0010,
		ST_DRIVE = 4'b0100,
		ST_HOLD = 4'b1000
	} ubp_state_t;

endpackage

// ### bench/ubp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// host side: mode 0 busy, 1 idle, 2 reset, 3 resume
// ----------------------------------------
module ubp_host_model (
	input wire logic pclk,
	input wire logic [1:0] mode,
	input wire logic resume_drive,
	output logic bus_se0,
	output logic bus_k,
	output logic bus_idle
);
	initial begin
		bus_se0 = 1'b0;
		bus_k = 1'b0;
		bus_idle = 1'b0;
	end
	// the host only listens while the device drives K
	always @(posedge pclk) begin
		bus_se0 <= (mode == 2'h2) && !resume_drive;
		bus_k <= (mode == 2'h3) && !resume_drive;
		bus_idle <= (mode == 2'h1);
	end
endmodule
`default_nettype wire

// ### bench/ubp_power_irq_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ubp_power_irq_tb_top;
	import ubp_pkg::*;
	typedef struct {logic w; logic [31:0] a; logic [31:0] d; logic [31:0] e;} ubp_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, rd, ex;
	logic [4:1] ep_dir_in = 4'hf, ep_flush = 0;
	logic [4:0] ep_in_rdy_clr = 0, ep_out_rdy_set = 0, ep_stall_set = 0;
	logic ep0_setup_end_set = 0, ep0_data_end_clr = 0;
	logic [1:0] mode = 0;
	logic err;
	int drive_cyc = 0;
	wire logic [31:0] prdata;
	wire logic pready, pslverr, bus_se0, bus_k, bus_idle, resume_drive, irq;
	int n_errors = 0, checks = 0, n, k;
	ubp_row_t rows[9] = '{'{0, ADDR_POWER_CTRL, 0, 0}, '{0, ADDR_EP_PEND, 0, 0},
		'{0, ADDR_BUS_PEND, 0, 0}, '{0, ADDR_EP_EN, 0, 32'h1f}, '{0, ADDR_BUS_EN, 0, 32'h04},
		'{1, ADDR_BUS_EN, 32'hff, 32'h05}, '{1, ADDR_POWER_CTRL, 32'hff, 32'h05},
		'{1, ADDR_POWER_CTRL, 0, 0}, '{1, 32'h5200_0150, 32'hff, 0}};
	always #2.5 pclk = ~pclk;
	// counts edges that see resume driven, free of sampling races
	always @(posedge pclk)
		if (resume_drive === 1'b1)
			drive_cyc <= drive_cyc + 1;
	ubp_power_irq #(.WAKE_CYCLES(20), .IDLE_CYCLES(30), .RSTDET_CYCLES(4)) ubp_power_irq_i (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .bus_se0, .bus_k, .bus_idle, .ep_dir_in, .ep_in_rdy_clr,
		.ep_out_rdy_set, .ep_stall_set, .ep_flush, .ep0_setup_end_set,
		.ep0_data_end_clr, .resume_drive, .irq);
	ubp_host_model ubp_host_model_i (.pclk, .mode, .resume_drive, .bus_se0, .bus_k,
		.bus_idle);
	task automatic test_done;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int i;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		if (i >= 50) begin
			n_errors++;
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge pclk);
		#1;
	endtask
	initial begin
		idle(2);
		presetn <= 1;
		foreach (rows[i]) begin
			if (rows[i].w) apb(1, rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].e);
		end
		chk(err, 1);
		$display("register table done");
		// every endpoint event kind, then write-zero keeps and write-one clears
		for (k = 0; k < 6; k++) begin
			ep_dir_in <= (k == 3) ? 4'h0 : 4'hf;
			@(posedge pclk);
			case (k)
				0: ep_in_rdy_clr <= 5'h1f;
				1: ep_flush <= 4'hf;
				2: ep_stall_set <= 5'h1f;
				3: ep_out_rdy_set <= 5'h1f;
				4: ep0_setup_end_set <= 1;
				default: ep0_data_end_clr <= 1;
			endcase
			@(posedge pclk);
			{ep_in_rdy_clr, ep_flush, ep_stall_set, ep_out_rdy_set} <= 0;
			{ep0_setup_end_set, ep0_data_end_clr} <= 0;
			idle(2);
			ex = (k == 1) ? 32'h1e : (k > 3) ? 32'h01 : 32'h1f;
			chk(irq, 1);
			rdchk(ADDR_EP_PEND, ex);
			apb(1, ADDR_EP_PEND, 0);
			rdchk(ADDR_EP_PEND, ex);
			apb(1, ADDR_EP_PEND, ex);
			rdchk(ADDR_EP_PEND, 0);
		end
		apb(1, ADDR_EP_EN, 32'h1e);
		ep_stall_set <= 5'h01;
		@(posedge pclk);
		ep_stall_set <= 0;
		idle(2);
		chk(irq, 0);
		apb(1, ADDR_EP_EN, 32'h1f);
		idle(1);
		chk(irq, 1);
		apb(1, ADDR_EP_PEND, 32'h1f);
		$display("endpoint events done");
		// idle without suspend allowed, then with it, then host resume
		apb(1, ADDR_BUS_EN, 32'h04);
		mode <= 1;
		idle(40);
		mode <= 0;
		rdchk(ADDR_BUS_PEND, 1);
		chk(err, 0);
		chk(irq, 0);
		rdchk(ADDR_POWER_CTRL, 0);
		apb(1, ADDR_BUS_PEND, 7);
		apb(1, ADDR_POWER_CTRL, 1);
		mode <= 1;
		idle(40);
		rdchk(ADDR_POWER_CTRL, 3);
		mode <= 3;
		idle(3);
		mode <= 0;
		idle(2);
		rdchk(ADDR_BUS_PEND, 3);
		rdchk(ADDR_POWER_CTRL, 1);
		chk(irq, 1);
		$display("suspend and resume done");
		// remote wakeup: full length, then software takes the held state back to active
		mode <= 1;
		idle(40);
		mode <= 0;
		apb(1, ADDR_BUS_PEND, 7);
		n = drive_cyc;
		apb(1, ADDR_POWER_CTRL, 5);
		k = 0;
		while (resume_drive !== 1'b1 && k < 5) begin
			idle(1);
			k++;
		end
		k = 0;
		while (resume_drive === 1'b1 && k < 100) begin
			idle(1);
			k++;
		end
		chk(drive_cyc - n, 20);
		rdchk(ADDR_POWER_CTRL, 3);
		apb(1, ADDR_POWER_CTRL, 5);
		idle(5);
		apb(1, ADDR_POWER_CTRL, 1);
		idle(2);
		chk(resume_drive, 0);
		rdchk(ADDR_POWER_CTRL, 1);
		$display("remote wakeup done");
		// host reset while awake, then a reset in mid-run
		apb(1, ADDR_BUS_PEND, 7);
		mode <= 2;
		idle(10);
		rdchk(ADDR_POWER_CTRL, 32'h09);
		rdchk(ADDR_BUS_PEND, 4);
		chk(irq, 1);
		mode <= 0;
		idle(3);
		rdchk(ADDR_POWER_CTRL, 1);
		// reset that wakes a suspended device: resume first, reset later
		mode <= 1;
		idle(40);
		apb(1, ADDR_BUS_PEND, 7);
		mode <= 2;
		idle(10);
		rdchk(ADDR_BUS_PEND, 2);
		idle(25);
		rdchk(ADDR_BUS_PEND, 6);
		mode <= 0;
		idle(3);
		presetn <= 0;
		idle(2);
		chk(irq, 0);
		presetn <= 1;
		rdchk(ADDR_BUS_PEND, 0);
		rdchk(ADDR_POWER_CTRL, 0);
		$display("bus reset and reset done");
		test_done();
	end
endmodule
`default_nettype wire
